/* File: shared/tec_params.svh */
// Constants of the timer/event counter with tone and PWM outputs.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
//
// Operation
// - Event mode counts pin; timer and pulse-width count prescaled clock.
// - Count up, reload on overflow, set flag.
// - Pulse-width: start on edge, stop, clear run.
// - Result held until software sets run again.
// - Pulse-width start needs an edge, not level.
// - Pulse-width overflow also reloads and requests interrupt.
// - Counter advances only while run bit set.
// - Event/timer modes: only software clears run.
// - Overflow wakes device from halt.
// - Interrupt enable low suppresses overflow service.
// - Stopped: data write loads preload and counter.
// - Running: data write loads preload only.
// - Counter read blocks the count clock.
// - Control bits 0 to 2 select prescaler.
// - Prescaler divides by two to the field.
// - Mode 01 event, 10 timer, 11 pulse-width.
// - Edge bit 0 rising, 1 falling.
// - Tone pin gated by its data bit.
// - Tone toggles at each overflow.
// - Tone pin as input stays a plain input.
// - PWM counter is the timer prescaler.
// - Duty splits: coarse bits 7-2, fine 1-0.
// - Four modulation cycles of 64 clocks each.
// - Cycle i high coarse+1 if i below fine.
// - PWM pin gated by its data bit when output.
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define TEC_IDX_INTERRUPT_CONTROL_REG    6'h0B
`define TEC_IDX_CNT     6'h0D
`define TEC_IDX_CTRL    6'h0E
`define TEC_IDX_PWM     6'h1A
`define TEC_IDX_PIN     6'h30

// Control register fields.
`define TEC_CTRL_PSC_LSB 0
`define TEC_CTRL_EDGE    3
`define TEC_CTRL_RUN     4
`define TEC_CTRL_MODE_LSB 6
`define TEC_CTRL_RST     8'h08
`define TEC_CTRL_WMASK   8'hDF

// Interrupt control register fields.
`define TEC_INTERRUPT_CONTROL_REG_ENA     0
`define TEC_INTERRUPT_CONTROL_REG_FLAG    5
`define TEC_INTERRUPT_CONTROL_REG_RST     8'h00

// Pin control register fields and reset value.
`define TEC_PIN_TONE_DAT 0
`define TEC_PIN_TONE_DIR 1
`define TEC_PIN_TONE_SEL 2
`define TEC_PIN_PWM_DAT  4
`define TEC_PIN_PWM_DIR  5
`define TEC_PIN_PWM_SEL  6
`define TEC_PIN_RST      8'h33

// Data register reset values and counter top.
`define TEC_CNT_RST      8'h00
`define TEC_PWM_RST      8'h00
`define TEC_CNT_TOP      8'hFF

`endif

/* File: shared/tec_pkg.sv */
// Types shared by the timer/event counter and its bench.
// Assumes the constants header is compiled alongside.
package tec_pkg;

    // Counter operating modes as held in the control register.
    typedef enum logic [1:0]
    {
        TEC_MODE_NONE  = 2'h0,
        TEC_MODE_EVENT = 2'h1,
        TEC_MODE_TIMER = 2'h2,
        TEC_MODE_PULSE = 2'h3
    } tec_mode_e;

    // Wishbone classic request from the master.
    typedef struct packed
    {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tec_wb_req_s;

    // Wishbone classic answer from the slave.
    typedef struct packed
    {
        logic        ack;
        logic [31:0] dat;
    } tec_wb_rsp_s;

endpackage

/* File: logic/tec_top.sv */
// Timer/event counter with tone output and (6+2)-bit PWM channel.
// Assumes one 100 MHz clock, a Wishbone classic master and an event
// input that may be asynchronous to the clock.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "tec_params.svh"

module tec_top
(
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // Register bus.
    input  wire tec_pkg::tec_wb_req_s i_wb,
    output      tec_pkg::tec_wb_rsp_s o_wb,
    // External event input pin.
    input  wire logic                 i_event_input_pin,
    // Shared tone pin, output side.
    output      logic                 o_tone_shared_pin,
    output      logic                 o_tone_shared_pin_oe,
    // Shared PWM pin, output side.
    output      logic                 o_pwm_shared_pin,
    output      logic                 o_pwm_shared_pin_oe,
    // Overflow interrupt request and wake-up pulse.
    output      logic                 o_overflow_irq,
    output      logic                 o_wake
);
    import tec_pkg::*;

    // Pulse-width measurement states.
    typedef enum logic
    {
        TEC_PW_WAIT,
        TEC_PW_COUNT
    } tec_pw_e;

    // True when the prescaler has reached the end of a period of
    // two to the given power system clocks.
    function automatic logic tec_psc_tick
    (
        input logic [7:0] psc,
        input logic [2:0] sel
    );
        logic [7:0] mask;
        mask = 8'h00;
        mask = (8'h01 << sel) - 8'h01;
        tec_psc_tick = ((psc & mask) == mask);
    endfunction

    // Registers.
    logic [7:0]  ctrl_q;          // Control register.
    logic [7:0]  interrupt_control_reg_q;          // Interrupt control register.
    logic [7:0]  pin_q;           // Pin control register.
    logic [7:0]  pwm_duty_value_q;// PWM duty register.
    logic [7:0]  preload_q;       // Preload register.
    logic [7:0]  count_q;         // The counter itself.
    logic [7:0]  psc_q;           // Prescaler, also the PWM counter.
    logic        sync1_q;         // First synchroniser stage.
    logic        sync2_q;         // Second synchroniser stage.
    logic        evt_prev_q;      // Previous synchronised level.
    tec_pw_e     pw_q;            // Pulse-width state.
    logic        tone_q;          // Tone toggle.
    logic        ovf_q;           // Registered overflow interrupt.
    logic        wake_q;          // Registered wake pulse.
    logic        tone_pin_q;      // Registered tone pin level.
    logic        tone_oe_q;       // Registered tone pin enable.
    logic        pwm_pin_q;       // Registered PWM pin level.
    logic        pwm_oe_q;        // Registered PWM pin enable.
    tec_wb_rsp_s rsp_q;           // Registered bus answer.

    // Decoded control fields.
    wire [2:0]   prescale_select = ctrl_q[`TEC_CTRL_PSC_LSB +: 3];
    wire         active_edge_bit = ctrl_q[`TEC_CTRL_EDGE];
    wire         count_run_bit   = ctrl_q[`TEC_CTRL_RUN];
    wire         mode_select_low = ctrl_q[`TEC_CTRL_MODE_LSB];
    wire         mode_select_high = ctrl_q[`TEC_CTRL_MODE_LSB + 1];
    wire         overflow_irq_enable = interrupt_control_reg_q[`TEC_INTERRUPT_CONTROL_REG_ENA];
    wire         overflow_request_flag = interrupt_control_reg_q[`TEC_INTERRUPT_CONTROL_REG_FLAG];
    tec_mode_e   mode;

    // Mode field decode; 00 leaves the counter idle.
    assign mode = tec_mode_e'({mode_select_high, mode_select_low});

    // Bus decode.  A request is served once; ack drops the next cycle.
    wire         bus_req   = i_wb.cyc & i_wb.stb & ~rsp_q.ack;
    wire         bus_wr    = bus_req & i_wb.we & i_wb.sel[0];
    wire [5:0]   bus_idx   = i_wb.adr[7:2];
    wire         hit_cnt   = (bus_idx == `TEC_IDX_CNT);
    wire         hit_ctrl  = (bus_idx == `TEC_IDX_CTRL);
    wire         hit_interrupt_control_reg  = (bus_idx == `TEC_IDX_INTERRUPT_CONTROL_REG);
    wire         hit_pwm   = (bus_idx == `TEC_IDX_PWM);
    wire         hit_pin   = (bus_idx == `TEC_IDX_PIN);
    wire         wr_cnt    = bus_wr & hit_cnt;
    wire         wr_ctrl   = bus_wr & hit_ctrl;
    wire         wr_interrupt_control_reg   = bus_wr & hit_interrupt_control_reg;
    wire         wr_pwm    = bus_wr & hit_pwm;
    wire         wr_pin    = bus_wr & hit_pin;
    wire [7:0]   wr_byte   = i_wb.dat[7:0];

    // A counter read in progress holds the count still so the value
    // returned is stable; a tick lost here is a known counting error.
    wire         rd_block  = i_wb.cyc & i_wb.stb & ~i_wb.we & hit_cnt;

    // Read data mux; unmapped addresses answer zero.
    wire [7:0]   rd_byte   =
        hit_cnt  ? count_q :
        hit_ctrl ? (ctrl_q & `TEC_CTRL_WMASK) :
        hit_interrupt_control_reg ? interrupt_control_reg_q :
        hit_pwm  ? pwm_duty_value_q :
        hit_pin  ? pin_q : 8'h00;

    // Edge detection on the synchronised input only.
    wire         rise      = sync2_q & ~evt_prev_q;
    wire         fall      = ~sync2_q & evt_prev_q;
    wire         act_edge  = active_edge_bit ? fall : rise;
    wire         ret_edge  = active_edge_bit ? rise : fall;

    // Internal count clock from the prescaler.
    wire         internal_count_clock =
        tec_psc_tick(psc_q, prescale_select);

    // Pulse-width: counting only between the start and return edges.
    wire         pw_active = (pw_q == TEC_PW_COUNT);
    wire         pw_end    = pw_active & ret_edge;

    // Count enable per mode, gated by run bit and read blocking.
    wire         cnt_src   =
        (mode == TEC_MODE_EVENT) ? act_edge :
        (mode == TEC_MODE_TIMER) ? internal_count_clock :
        (mode == TEC_MODE_PULSE) ? (internal_count_clock & pw_active) :
        1'b0;
    wire         cnt_en    = count_run_bit & cnt_src & ~rd_block;
    wire         overflow  = cnt_en & (count_q == `TEC_CNT_TOP);

    // PWM fields and waveform from the shared prescaler.
    wire [5:0]   duty_coarse = pwm_duty_value_q[7:2];
    wire [1:0]   duty_fine   = pwm_duty_value_q[1:0];
    wire [1:0]   mod_index   = psc_q[7:6];
    wire [5:0]   mod_pos     = psc_q[5:0];
    wire [6:0]   high_len    =
        {1'b0, duty_coarse} + {6'h00, (mod_index < duty_fine)};
    wire         pwm_wave    = ({1'b0, mod_pos} < high_len);

    // Pin drive decisions.
    wire         tone_drive  = pin_q[`TEC_PIN_TONE_SEL] &
                               ~pin_q[`TEC_PIN_TONE_DIR];
    wire         pwm_drive   = pin_q[`TEC_PIN_PWM_SEL] &
                               ~pin_q[`TEC_PIN_PWM_DIR];

    // Bus answer: one-cycle ack, read data latched with it.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q.ack <= bus_req;
            rsp_q.dat <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Software-owned registers.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_q            <= `TEC_PIN_RST;
            pwm_duty_value_q <= `TEC_PWM_RST;
        end
        else
        begin
            if (wr_pin)
            begin
                pin_q <= wr_byte;
            end
            if (wr_pwm)
            begin
                pwm_duty_value_q <= wr_byte;
            end
        end
    end

    // Control register.  Only the pulse-width end clears run in
    // hardware; a software write in the same cycle takes priority.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `TEC_CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= wr_byte & `TEC_CTRL_WMASK;
        end
        else if (pw_end && count_run_bit)
        begin
            ctrl_q[`TEC_CTRL_RUN] <= 1'b0;
        end
    end

    // Interrupt control.  A new overflow wins over a clear by software.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            interrupt_control_reg_q <= `TEC_INTERRUPT_CONTROL_REG_RST;
        end
        else
        begin
            if (wr_interrupt_control_reg)
            begin
                interrupt_control_reg_q <= wr_byte;
            end
            if (overflow)
            begin
                interrupt_control_reg_q[`TEC_INTERRUPT_CONTROL_REG_FLAG] <= 1'b1;
            end
        end
    end

    // Preload and counter.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            preload_q <= `TEC_CNT_RST;
            count_q   <= `TEC_CNT_RST;
        end
        else
        begin
            if (wr_cnt)
            begin
                preload_q <= wr_byte;
            end
            if (wr_cnt && !count_run_bit)
            begin
                count_q <= wr_byte;
            end
            else if (overflow)
            begin
                count_q <= preload_q;
            end
            else if (cnt_en)
            begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // Free-running prescaler; it is the PWM counter too.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            psc_q <= 8'h00;
        end
        else
        begin
            psc_q <= psc_q + 8'h01;
        end
    end

    // Two-stage synchroniser, then the edge history flop.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync1_q    <= 1'b0;
            sync2_q    <= 1'b0;
            evt_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q    <= i_event_input_pin;
            sync2_q    <= sync1_q;
            evt_prev_q <= sync2_q;
        end
    end

    // Pulse-width state: armed by the run bit, started by an edge.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pw_q <= TEC_PW_WAIT;
        end
        else
        begin
            case (pw_q)
                TEC_PW_WAIT:
                begin
                    // A level alone never starts a measurement.
                    if (count_run_bit && mode == TEC_MODE_PULSE && act_edge)
                    begin
                        pw_q <= TEC_PW_COUNT;
                    end
                end
                TEC_PW_COUNT:
                begin
                    // Ends on return edge or when software stops it;
                    // with run clear, later edges are ignored.
                    if (pw_end || !count_run_bit ||
                        mode != TEC_MODE_PULSE)
                    begin
                        pw_q <= TEC_PW_WAIT;
                    end
                end
                default:
                begin
                    pw_q <= TEC_PW_WAIT;
                end
            endcase
        end
    end

    // Tone toggle at each overflow, giving half the overflow rate.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tone_q <= 1'b0;
        end
        else if (overflow)
        begin
            tone_q <= ~tone_q;
        end
    end

    // Registered outputs, so every pin and request comes from a flop.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ovf_q      <= 1'b0;
            wake_q     <= 1'b0;
            tone_pin_q <= 1'b0;
            tone_oe_q  <= 1'b0;
            pwm_pin_q  <= 1'b0;
            pwm_oe_q   <= 1'b0;
        end
        else
        begin
            ovf_q      <= overflow_request_flag & overflow_irq_enable;
            wake_q     <= overflow;
            tone_oe_q  <= tone_drive;
            tone_pin_q <= tone_drive & pin_q[`TEC_PIN_TONE_DAT] &
                          tone_q;
            pwm_oe_q   <= pwm_drive;
            pwm_pin_q  <= pwm_drive & pin_q[`TEC_PIN_PWM_DAT] &
                          pwm_wave;
        end
    end

    // Output assignments.
    assign o_wb                 = rsp_q;
    assign o_overflow_irq       = ovf_q;
    assign o_wake               = wake_q;
    assign o_tone_shared_pin    = tone_pin_q;
    assign o_tone_shared_pin_oe = tone_oe_q;
    assign o_pwm_shared_pin     = pwm_pin_q;
    assign o_pwm_shared_pin_oe  = pwm_oe_q;

endmodule

/* File: tb/tec_evt_src.sv */
// Behavioural source that drives the external event/pulse pin.
// Assumes the bench calls its tasks from the system clock domain.
`timescale 1ns/1ps

module tec_evt_src
(
    // Pacing clock.
    input  wire logic i_clk,
    // Event pin level, always driven.
    output      logic o_pin
);
    // The pin starts low so that the first rise is a clean edge.
    initial o_pin = 1'h0;

    // Settles the pin, then waits out the synchroniser and history.
    task automatic drive(input logic v);
        @(posedge i_clk);
        o_pin <= v;
        repeat (6) @(posedge i_clk);
    endtask

    // One high pulse of n system clocks, then a settling gap.
    task automatic pulse(input int n);
        @(posedge i_clk);
        o_pin <= 1'h1;
        repeat (n) @(posedge i_clk);
        o_pin <= 1'h0;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

/* File: tb/tec_top_sva.sv */
// Port checks of the timer/event counter top.
// Assumes it is bound into the top module by the bind at the foot.
`timescale 1ns/1ps
`include "tec_params.svh"

module tec_top_sva
(
    // Clock, reset and bus.
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    input wire tec_pkg::tec_wb_req_s i_wb,
    input wire tec_pkg::tec_wb_rsp_s o_wb,
    // Pins and requests.
    input wire logic                 i_event_input_pin,
    input wire logic                 o_tone_shared_pin,
    input wire logic                 o_tone_shared_pin_oe,
    input wire logic                 o_pwm_shared_pin,
    input wire logic                 o_pwm_shared_pin_oe,
    input wire logic                 o_overflow_irq,
    input wire logic                 o_wake
);
    logic [7:0] pin_q;  // Shadow of the pin control register.
    logic       en_q;   // Shadow of the overflow enable bit.
    wire logic  take_w; // A write is taken at this edge.
    wire logic [5:0] idx_w;

    assign take_w = i_wb.cyc & i_wb.stb & i_wb.we & i_wb.sel[0] & ~o_wb.ack;
    assign idx_w = i_wb.adr[7:2];

    // Shadows follow taken writes, so no design state is peeked at.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_q <= `TEC_PIN_RST;
            en_q  <= 1'h0;
        end
        else if (take_w && idx_w == `TEC_IDX_PIN)
            pin_q <= i_wb.dat[7:0];
        else if (take_w && idx_w == `TEC_IDX_INTERRUPT_CONTROL_REG)
            en_q <= i_wb.dat[`TEC_INTERRUPT_CONTROL_REG_ENA];
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // A request seen while no answer is pending.
    sequence bus_take_s;
        i_wb.cyc && i_wb.stb && !o_wb.ack;
    endsequence

    bus_answer_a: assert property (bus_take_s |=> o_wb.ack)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (o_wb.ack |=> !o_wb.ack)
        else $error("ack held longer than one cycle");
    rdata_idle_a: assert property (!o_wb.ack |-> o_wb.dat == 32'h0)
        else $error("read data not zero outside ack");
    rdata_upper_a: assert property (o_wb.ack |-> o_wb.dat[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    irq_enable_a: assert property (!en_q |=> !o_overflow_irq)
        else $error("interrupt raised while disabled");
    // The request is registered from the flag, so it lags wake by one.
    wake_irq_a: assert property (o_wake && en_q |=> o_overflow_irq)
        else $error("wake without interrupt request");
    tone_oe_a: assert property (o_tone_shared_pin_oe ==
        ($past(pin_q[2]) & ~$past(pin_q[1])))
        else $error("tone output enable wrong");
    tone_gate_a: assert property (!$past(pin_q[0]) |-> !o_tone_shared_pin)
        else $error("tone pin not held low");
    pwm_oe_a: assert property (o_pwm_shared_pin_oe ==
        ($past(pin_q[6]) & ~$past(pin_q[5])))
        else $error("pwm output enable wrong");
    pwm_gate_a: assert property (!$past(pin_q[4]) |-> !o_pwm_shared_pin)
        else $error("pwm pin not held low");
endmodule

bind tec_top tec_top_sva sva_u
(
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb(i_wb), .o_wb(o_wb),
    .i_event_input_pin(i_event_input_pin),
    .o_tone_shared_pin(o_tone_shared_pin),
    .o_tone_shared_pin_oe(o_tone_shared_pin_oe),
    .o_pwm_shared_pin(o_pwm_shared_pin),
    .o_pwm_shared_pin_oe(o_pwm_shared_pin_oe),
    .o_overflow_irq(o_overflow_irq), .o_wake(o_wake)
);

/* File: tb/timer_event_counter_tone_pwm_tb_top.sv */
// Self-checking bench of the timer/event counter with tone and PWM.
// Assumes the design top, its bound checker and the event source.
`timescale 1ns/1ps
`include "tec_params.svh"

module timer_event_counter_tone_pwm_tb_top;
    import tec_pkg::*;

    localparam logic [7:0] A_INT = {`TEC_IDX_INTERRUPT_CONTROL_REG, 2'h0};
    localparam logic [7:0] A_CNT = {`TEC_IDX_CNT, 2'h0};
    localparam logic [7:0] A_CTL = {`TEC_IDX_CTRL, 2'h0};
    localparam logic [7:0] A_PWM = {`TEC_IDX_PWM, 2'h0};
    localparam logic [7:0] A_PIN = {`TEC_IDX_PIN, 2'h0};

    logic        i_clk;     // System clock.
    logic        i_rst_b;   // Reset, active low.
    tec_wb_req_s wb_i;      // Bus request.
    tec_wb_rsp_s wb_o;      // Bus answer.
    logic        evt_pin;   // Event pin from the source model.
    logic        tone, tone_oe, pwm, pwm_oe, irq, wake;
    int          errors;    // Mismatches.
    int          tests_run; // Comparisons.
    logic [7:0]  q;         // Last read data.

    tec_top dut_u
    (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb(wb_i), .o_wb(wb_o),
        .i_event_input_pin(evt_pin), .o_tone_shared_pin(tone),
        .o_tone_shared_pin_oe(tone_oe), .o_pwm_shared_pin(pwm),
        .o_pwm_shared_pin_oe(pwm_oe), .o_overflow_irq(irq), .o_wake(wake)
    );

    tec_evt_src evt_u (.i_clk(i_clk), .o_pin(evt_pin));

    // Free-running 100 MHz clock.
    initial
    begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic ok);
        tests_run++;
        if (ok !== 1'h1)
        begin
            errors++;
            $display("[ERR] %0t condition false, data %h", $time, q);
        end
    endtask

    // One classic cycle; the wait is bounded so a dead slave shows up.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        wb_i <= '{1'h1, 1'h1, w, a, s, {24'h0, d}};
        @(posedge i_clk);
        while (wb_o.ack !== 1'h1 && n < 50)
        begin
            @(posedge i_clk);
            n++;
        end
        if (n == 50)
            chk1(1'h0);
        q = wb_o.dat[7:0];
        wb_i <= '0;
        @(posedge i_clk);
    endtask

    task automatic t_reset();
        logic [7:0] adr [6] = '{A_CTL, A_INT, A_PIN, A_PWM, A_CNT, 8'h04};
        logic [7:0] exp [6] = '{`TEC_CTRL_RST, `TEC_INTERRUPT_CONTROL_REG_RST, `TEC_PIN_RST,
                                `TEC_PWM_RST, `TEC_CNT_RST, 8'h00};
        foreach (adr[i])
        begin
            wb(1'h0, adr[i], 8'h00);
            chk8(q, exp[i]);
        end
        wb(1'h1, 8'h04, 8'hA5);
        wb(1'h0, 8'h04, 8'h00);
        chk8(q, 8'h00);
        wb(1'h1, A_CTL, 8'h2F);
        wb(1'h0, A_CTL, 8'h00);
        chk8(q, 8'h0F);
        // A write without the low byte lane is acked but changes nothing.
        wb(1'h1, A_PWM, 8'h5A, 4'hE);
        wb(1'h0, A_PWM, 8'h00);
        chk8(q, `TEC_PWM_RST);
        $display("test reset done");
    endtask

    task automatic t_load();
        wb(1'h1, A_CTL, 8'h80);
        wb(1'h1, A_CNT, 8'hF0);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, 8'hF0);
        wb(1'h1, A_INT, 8'h00);
        wb(1'h1, A_CTL, 8'h90);
        wb(1'h1, A_CNT, 8'h10);
        wb(1'h0, A_CNT, 8'h00);
        chk1(q > 8'hF0);
        repeat (40) @(posedge i_clk);
        wb(1'h0, A_INT, 8'h00);
        chk8(q & 8'h20, 8'h20);
        wb(1'h0, A_CNT, 8'h00);
        chk1(q >= 8'h10 && q < 8'h40);
        wb(1'h0, A_CTL, 8'h00);
        chk8(q, 8'h90);
        wb(1'h1, A_CTL, 8'h80);
        $display("test load done");
    endtask

    task automatic t_psc();
        for (int p = 0; p < 8; p++)
        begin
            wb(1'h1, A_CNT, 8'h00);
            wb(1'h1, A_CTL, 8'h90 | p[7:0]);
            repeat (128) @(posedge i_clk);
            wb(1'h1, A_CTL, 8'h80 | p[7:0]);
            wb(1'h0, A_CNT, 8'h00);
            chk1(q >= (8'h80 >> p) && q <= (8'h80 >> p) + 8'h4);
        end
        $display("test prescale done");
    endtask

    task automatic t_event();
        wb(1'h1, A_CTL, 8'h40);
        wb(1'h1, A_CNT, 8'h00);
        wb(1'h1, A_CTL, 8'h50);
        evt_u.drive(1'h1);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, 8'h01);
        wb(1'h1, A_CTL, 8'h58);
        evt_u.drive(1'h0);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, 8'h02);
        evt_u.drive(1'h1);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, 8'h02);
        $display("test event done");
    endtask

    task automatic t_pulse();
        logic [7:0] r;
        wb(1'h1, A_CTL, 8'hC0);
        wb(1'h1, A_CNT, 8'hF0);
        wb(1'h1, A_INT, 8'h00);
        wb(1'h1, A_CTL, 8'hD0);
        repeat (20) @(posedge i_clk);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, 8'hF0);
        evt_u.drive(1'h0);
        evt_u.pulse(40);
        wb(1'h0, A_CTL, 8'h00);
        chk8(q, 8'hC0);
        wb(1'h0, A_INT, 8'h00);
        chk8(q & 8'h20, 8'h20);
        wb(1'h0, A_CNT, 8'h00);
        chk1(q >= 8'hF0);
        r = q;
        evt_u.pulse(20);
        wb(1'h0, A_CNT, 8'h00);
        chk8(q, r);
        $display("test pulse done");
    endtask

    task automatic t_irq();
        int n;
        wb(1'h1, A_CTL, 8'h80);
        wb(1'h1, A_CNT, 8'hF0);
        wb(1'h1, A_INT, 8'h01);
        wb(1'h1, A_CTL, 8'h90);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            while (wake !== 1'h1 && n < 100)
            begin
                @(posedge i_clk);
                n++;
            end
            chk1(wake === 1'h1);
            // The request follows the flag one cycle behind the wake pulse.
            @(posedge i_clk);
            chk1(irq === !k[0]);
            // Clear only once, so the second flag must still read set.
            if (k == 0)
                wb(1'h1, A_INT, 8'h00);
        end
        wb(1'h0, A_INT, 8'h00);
        chk8(q & 8'h20, 8'h20);
        wb(1'h1, A_CTL, 8'h80);
        $display("test interrupt done");
    endtask

    task automatic t_pins();
        logic [7:0] duty [3] = '{8'h00, 8'h41, 8'hFF};
        int   n;
        logic t0;
        wb(1'h1, A_CNT, 8'hC0);
        wb(1'h1, A_PIN, 8'h55);
        wb(1'h1, A_CTL, 8'h90);
        for (int k = 0; k < 2; k++)
        begin
            t0 = tone;
            n = 0;
            while (tone === t0 && n < 300)
            begin
                @(posedge i_clk);
                n++;
            end
        end
        chk8(n[7:0], 8'h40);
        foreach (duty[i])
        begin
            wb(1'h1, A_PWM, duty[i]);
            repeat (256) @(posedge i_clk);
            count_hi(n);
            chk8(n[7:0], duty[i]);
        end
        wb(1'h1, A_PIN, 8'h46);
        count_hi(n);
        chk8(n[7:0], 8'h00);
        chk1(tone_oe === 1'h0 && pwm_oe === 1'h1);
        wb(1'h1, A_CTL, 8'h80);
        $display("test pins done");
    endtask

    // Counts high samples of the PWM pin over one full PWM cycle.
    task automatic count_hi(output int h);
        h = 0;
        repeat (256)
        begin
            @(posedge i_clk);
            if (pwm === 1'h1)
                h++;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence: reset for 16 clocks, then each scenario in turn.
    initial
    begin
        errors = 0;
        tests_run = 0;
        i_rst_b = 1'h0;
        wb_i = '0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        t_reset();
        t_load();
        t_psc();
        t_event();
        t_pulse();
        t_irq();
        t_pins();
        end_of_test();
    end

    // The run needs well under 10000 clocks; a hang ends it here.
    initial
    begin
        #200000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
